// ---- logic/guest_entry_check_and_exit.sv ----
/*
  Guest entry consistency check and ordered guest exit sequencer with
  intercept ordering and exit recording, as an APB slave.
  Assumes one clock (pclk), an APB master, and software acting as the
  core that reports guest events through the cause register.
*/
// The register offsets and the APB slave port are this design's own decisions.
// What this block does
// - Failed entry check exits at once with the invalid state exit code.
// - Reject cache-disable clear with no-write-through set, or high halves nonzero.
// - Reject any reserved bit set in control registers 3, 4, feature register.
// - Reject entry without virtualization enable, entry intercept, or nonzero space id.
// - Reject long mode combinations that are not allowed.
// - Reject tables reaching max physical address, or illegal event injection.
// - Accept protection off with paging on at entry, except with long mode enabled.
// - Sign-extend loaded segment base on entry and exit.
// - Entry acts as one host instruction for resume and trace flags.
// - Guest resume and trace flags act on the first guest instruction only.
// - Exit clears interrupt flag, then writes guest state back.
// - Exit records reason and two detail words.
// - Exit clears intercepts, space id, virtual interrupt bits, time offset.
// - Exception while reloading host segments causes shutdown.
// - With host paext set, host page pointer entries with illegal state cause shutdown.
// - Exit forces protection on, v86 off, privilege zero, breakpoints off.
// - Bad host state shuts down; bad host ip raises host protection fault.
// - Exception intercepts are taken before double fault and delivery.
// - Intercepted external interrupt stays pending.
// - Instruction intercepts rank after simple exceptions, before operand ones.
// - Trap exits save state after the instruction, ip at the next one.
// - Next sequential ip saved for listed exit classes, else zero.
// - Entry saves host, loads guest, then checks.
`timescale 1ns/10ps
module guest_entry_check_and_exit import guest_exit_pkg::*; #(
  parameter int VA_WIDTH = 48,
  parameter logic [31:0] MAX_PA_PAGE = 32'h0100_0000,
  parameter bit LONG_MODE_OK = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic glob_intr,
  output logic guest_running,
  output logic shutdown
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  regs_t s_q;
  regs_t s_d;
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic bad;
  logic [2:0] win;
  logic is_exit;

  // Bits above the virtual address width copy its top bit
  function automatic logic [63:0] canon(input logic [63:0] b);
    logic [63:0] m;
    m = {64{1'b1}} << VA_WIDTH;
    canon = b[VA_WIDTH-1] ? (b | m) : (b & ~m);
  endfunction : canon

  // Read data and error flag are taken at setup and stand through access
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = psel && penable && s_q.err;
  assign glob_intr = s_q.glob_intr;
  assign guest_running = (s_q.st == S_GUEST);
  assign shutdown = s_q.shut;

  // ----------------------------------------------------------------
  // Guest state consistency check
  // ----------------------------------------------------------------
  always_comb begin
    logic lm;
    lm = s_q.extf[EXT_LMEN] && s_q.cr0l[CR0_PAGING];
    bad = 1'b0;
    // Any single failed check rejects the entry
    if (!s_q.extf[EXT_SVEN] || !s_q.gm.entry_icpt || s_q.gm.space_id == 16'h0000) begin
      bad = 1'b1;
    end
    if ((!s_q.cr0l[CR0_CDIS] && s_q.cr0l[CR0_NOWT]) || s_q.cr0h != RST_WORD) begin
      bad = 1'b1;
    end
    if (s_q.dsth != RST_WORD || s_q.dcth != RST_WORD) begin
      bad = 1'b1;
    end
    if ((s_q.cr3l & CR3L_RSVD) != RST_WORD || (s_q.cr3h & CR3H_RSVD) != RST_WORD) begin
      bad = 1'b1;
    end
    if ((s_q.cr4 & CR4_RSVD) != RST_WORD || (s_q.extf & EXTF_RSVD) != RST_WORD) begin
      bad = 1'b1;
    end
    if (!LONG_MODE_OK && (s_q.extf[EXT_LMEN] || s_q.extf[EXT_LMACT])) begin
      bad = 1'b1;
    end
    if (lm && (!s_q.cr4[CR4_PAEXT] || !s_q.cr0l[CR0_PROT])) begin
      bad = 1'b1;
    end
    if (lm && s_q.cr4[CR4_PAEXT] && s_q.gm.cs_long && s_q.gm.cs_dflt) begin
      bad = 1'b1;
    end
    if (s_q.msr_top >= MAX_PA_PAGE || s_q.io_top >= MAX_PA_PAGE || s_q.gm.evinj_bad) begin
      bad = 1'b1;
    end
    // Protection off with paging on is rejected here only when long mode is active (lm)
  end

  // ----------------------------------------------------------------
  // Event ordering
  // ----------------------------------------------------------------
  // Winners that do not exit leave the guest running; it takes them itself
  always_comb begin
    win = WIN_PLAIN;
    is_exit = 1'b1;
    if (s_q.cause.exc_icpt) begin
      win = WIN_EXC_ICPT;
    end else if (s_q.cause.simple_exc) begin
      win = WIN_SIMPLE;
      is_exit = 1'b0;
    end else if (s_q.cause.bp_hit) begin
      win = WIN_BREAK;
      is_exit = 1'b0;
    end else if (s_q.cause.instr_icpt) begin
      win = WIN_INSTR;
    end else if (s_q.cause.opnd_exc) begin
      win = WIN_OPERAND;
      is_exit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rd = RST_WORD;
    case (paddr)
      OFF_CTRL: rd = RST_WORD;
      OFF_CAUSE: rd = s_q.cause;
      OFF_INFO1: rd = s_q.info1;
      OFF_INFO2: rd = s_q.info2;
      OFF_CR0L: rd = s_q.cr0l;
      OFF_CR0H: rd = s_q.cr0h;
      OFF_CR3L: rd = s_q.cr3l;
      OFF_CR3H: rd = s_q.cr3h;
      OFF_CR4: rd = s_q.cr4;
      OFF_EXTF: rd = s_q.extf;
      OFF_DSTH: rd = s_q.dsth;
      OFF_DCTH: rd = s_q.dcth;
      OFF_GMISC: rd = s_q.gm;
      OFF_MSRTOP: rd = s_q.msr_top;
      OFF_IOTOP: rd = s_q.io_top;
      OFF_NRIPIN: rd = s_q.seq_ip_in;
      OFF_STAT: rd = {17'h00000, s_q.win, s_q.guest_trace_trap,
                      s_q.st != S_IDLE, s_q.chk_fail, s_q.intr_pend,
                      s_q.entry_bp_supp, s_q.trace_first, s_q.first_bp_supp,
                      s_q.host_dbg_trap, s_q.host_gp, s_q.shut,
                      s_q.st == S_GUEST,
                      s_q.glob_intr};
      OFF_XREASON: rd = s_q.x_reason;
      OFF_XINFO1: rd = s_q.x_info1;
      OFF_XINFO2: rd = s_q.x_info2;
      OFF_XNRIP: rd = s_q.x_seq_ip;
      OFF_SEGL: rd = s_q.seg[31:0];
      OFF_SEGH: rd = s_q.seg[63:32];
      OFF_VIRT: rd = s_q.virt;
      OFF_TSOFF: rd = s_q.ts;
      OFF_RIPIN: rd = s_q.rip_in;
      OFF_WBVIRT: rd = s_q.wb_virt;
      OFF_WBRIP: rd = s_q.wb_rip;
      OFF_HOST: rd = s_q.host;
      // Internal copies show whether exit has cleared them
      OFF_SPACE: rd = {s_q.icpt_on, s_q.iv.vmask, s_q.iv.virq, |s_q.its, 12'h000,
                       s_q.cur_space};
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (setup) begin
      s_d.rdata = pwrite ? RST_WORD : rd;
      s_d.err = !hit;
    end
    if (wr) begin
      case (paddr)
        OFF_CAUSE: s_d.cause = cause_t'(pwdata);
        OFF_INFO1: s_d.info1 = pwdata;
        OFF_INFO2: s_d.info2 = pwdata;
        OFF_CR0L: s_d.cr0l = pwdata;
        OFF_CR0H: s_d.cr0h = pwdata;
        OFF_CR3L: s_d.cr3l = pwdata;
        OFF_CR3H: s_d.cr3h = pwdata;
        OFF_CR4: s_d.cr4 = pwdata;
        OFF_EXTF: s_d.extf = pwdata;
        OFF_DSTH: s_d.dsth = pwdata;
        OFF_DCTH: s_d.dcth = pwdata;
        OFF_GMISC: s_d.gm = gmisc_t'(pwdata);
        OFF_MSRTOP: s_d.msr_top = pwdata;
        OFF_IOTOP: s_d.io_top = pwdata;
        OFF_NRIPIN: s_d.seq_ip_in = pwdata;
        OFF_SEGL: s_d.seg[31:0] = pwdata;
        OFF_SEGH: s_d.seg[63:32] = pwdata;
        OFF_VIRT: s_d.virt = virt_t'(pwdata);
        OFF_TSOFF: s_d.ts = pwdata;
        OFF_RIPIN: s_d.rip_in = pwdata;
        OFF_HOST: s_d.host = host_t'(pwdata);
        OFF_CTRL: begin
          if (pwdata[CTRL_INTR_ACK]) begin
            s_d.intr_pend = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Reserved fields of the cause, misc, virtual and host words read as zero whatever software writes
    s_d.cause.rsvd = 5'h00;
    s_d.gm.rsvd = 10'h000;
    s_d.virt.rsvd = 25'h0000000;
    s_d.host.rsvd = 13'h0000;

    // --------------------------------------------------------------
    // Sequencer steps: entry takes three cycles, exit eight
    // --------------------------------------------------------------
    case (s_q.st)
      S_IDLE: begin
        if (wr && paddr == OFF_CTRL && pwdata[CTRL_ENTRY]) begin
          s_d.st = S_SAVE_HOST;
        end
      end
      S_SAVE_HOST: begin
        s_d.entry_bp_supp = s_q.host.resume;
        s_d.host_gp = 1'b0;
        s_d.host_dbg_trap = 1'b0;
        s_d.st = S_LOAD;
      end
      S_LOAD: begin
        s_d.seg = canon(s_q.seg);
        s_d.iv = s_q.virt;
        s_d.its = s_q.ts;
        s_d.cur_space = s_q.gm.space_id;
        s_d.icpt_on = 1'b1;
        s_d.first_bp_supp = s_q.gm.gresume;
        s_d.trace_first = s_q.gm.gtrc;
        s_d.guest_trace_trap = 1'b0;
        s_d.st = S_CHECK;
      end
      S_CHECK: begin
        s_d.chk_fail = bad;
        if (bad) begin
          s_d.st = S_X_INTR;
        end else begin
          // Interrupts come on only once the guest state is accepted
          s_d.glob_intr = 1'b1;
          s_d.st = S_GUEST;
        end
      end
      S_GUEST: begin
        // Guest flags act on the first guest instruction only
        if (wr && paddr == OFF_CTRL && pwdata[CTRL_RETIRE]) begin
          s_d.first_bp_supp = 1'b0;
          s_d.guest_trace_trap = s_q.trace_first;
          s_d.trace_first = 1'b0;
        end
        if (wr && paddr == OFF_CTRL && pwdata[CTRL_EXIT]) begin
          s_d.win = win;
          if (is_exit) begin
            s_d.st = S_X_INTR;
          end
        end
      end
      S_X_INTR: begin
        s_d.glob_intr = 1'b0;
        s_d.st = S_X_WB;
      end
      S_X_WB: begin
        // Internal copies go back before the clear step wipes them
        s_d.wb_virt = s_q.iv;
        s_d.wb_rip = s_q.cause.trap ? s_q.seq_ip_in : s_q.rip_in;
        s_d.seg = canon(s_q.seg);
        s_d.st = S_X_REASON;
      end
      S_X_REASON: begin
        if (s_q.chk_fail) begin
          s_d.x_reason = INVALID_CODE;
          s_d.x_info1 = RST_WORD;
          s_d.x_info2 = RST_WORD;
          s_d.x_seq_ip = RST_WORD;
        end else begin
          s_d.x_reason = {16'h0000, s_q.cause.reason};
          s_d.x_info1 = s_q.info1;
          s_d.x_info2 = s_q.info2;
          case (s_q.cause.cls)
            CLS_INSTR, CLS_MSR, CLS_PORTIO, CLS_BREAKPT, CLS_OVERFLOW, CLS_BOUND:
              s_d.x_seq_ip = s_q.seq_ip_in;
            default: s_d.x_seq_ip = RST_WORD;
          endcase
          // This set follows the bus clear above, so it wins in a shared cycle
          if (s_q.cause.ext_intr || s_q.cause.cls == CLS_EXTINT) begin
            s_d.intr_pend = 1'b1;
          end
        end
        s_d.st = S_X_CLEAR;
      end
      S_X_CLEAR: begin
        s_d.icpt_on = 1'b0;
        s_d.cur_space = 16'h0000;
        s_d.iv.virq = 1'b0;
        s_d.iv.vmask = 1'b0;
        s_d.its = RST_WORD;
        s_d.first_bp_supp = 1'b0;
        s_d.trace_first = 1'b0;
        s_d.st = S_X_RELOAD;
      end
      S_X_RELOAD: begin
        // The core reports reload faults through the host word
        s_d.st = s_q.host.reload_exc ? S_SHUTDOWN : S_X_PTRS;
      end
      S_X_PTRS: begin
        s_d.st = (s_q.host.paext && s_q.host.ptr_bad) ? S_SHUTDOWN : S_X_FORCE;
      end
      S_X_FORCE: begin
        // Mode bits are forced before the host state is checked
        s_d.host.prot = 1'b1;
        s_d.host.vm86 = 1'b0;
        s_d.host.priv = 2'h0;
        s_d.host.dbg_ctl = 8'h00;
        s_d.st = S_X_HCHECK;
      end
      S_X_HCHECK: begin
        if (s_q.host.chk_bad) begin
          s_d.st = S_SHUTDOWN;
        end else begin
          s_d.host_gp = s_q.host.rip_bad;
          s_d.host_dbg_trap = s_q.host.trc;
          s_d.host.resume = 1'b0;
          s_d.entry_bp_supp = 1'b0;
          s_d.st = S_IDLE;
        end
      end
      S_SHUTDOWN: begin
        // Only reset leaves shutdown
        s_d.shut = 1'b1;
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : guest_entry_check_and_exit

// ---- logic/guest_exit_pkg.sv ----
/*
  Package for the guest entry check and exit sequencer: register offsets,
  field positions, reset values, exit classes and the state record.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package guest_exit_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CAUSE = 8'h04;
  localparam logic [7:0] OFF_INFO1 = 8'h08;
  localparam logic [7:0] OFF_INFO2 = 8'h0c;
  localparam logic [7:0] OFF_CR0L = 8'h10;
  localparam logic [7:0] OFF_CR0H = 8'h14;
  localparam logic [7:0] OFF_CR3L = 8'h18;
  localparam logic [7:0] OFF_CR3H = 8'h1c;
  localparam logic [7:0] OFF_CR4 = 8'h20;
  localparam logic [7:0] OFF_EXTF = 8'h24;
  localparam logic [7:0] OFF_DSTH = 8'h28;
  localparam logic [7:0] OFF_DCTH = 8'h2c;
  localparam logic [7:0] OFF_GMISC = 8'h30;
  localparam logic [7:0] OFF_MSRTOP = 8'h34;
  localparam logic [7:0] OFF_IOTOP = 8'h38;
  localparam logic [7:0] OFF_NRIPIN = 8'h3c;
  localparam logic [7:0] OFF_STAT = 8'h40;
  localparam logic [7:0] OFF_XREASON = 8'h44;
  localparam logic [7:0] OFF_XINFO1 = 8'h48;
  localparam logic [7:0] OFF_XINFO2 = 8'h4c;
  localparam logic [7:0] OFF_XNRIP = 8'h50;
  localparam logic [7:0] OFF_SEGL = 8'h54;
  localparam logic [7:0] OFF_SEGH = 8'h58;
  localparam logic [7:0] OFF_VIRT = 8'h5c;
  localparam logic [7:0] OFF_TSOFF = 8'h60;
  localparam logic [7:0] OFF_RIPIN = 8'h64;
  localparam logic [7:0] OFF_WBVIRT = 8'h68;
  localparam logic [7:0] OFF_WBRIP = 8'h6c;
  localparam logic [7:0] OFF_HOST = 8'h70;
  localparam logic [7:0] OFF_SPACE = 8'h74;
  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int CTRL_ENTRY = 0;
  localparam int CTRL_EXIT = 1;
  localparam int CTRL_INTR_ACK = 2;
  localparam int CTRL_RETIRE = 3;
  localparam int CR0_PROT = 0;
  localparam int CR0_NOWT = 29;
  localparam int CR0_CDIS = 30;
  localparam int CR0_PAGING = 31;
  localparam int CR4_PAEXT = 5;
  localparam int EXT_LMEN = 8;
  localparam int EXT_LMACT = 10;
  localparam int EXT_SVEN = 12;
  localparam logic [31:0] CR3L_RSVD = 32'h0000_0fe7;
  localparam logic [31:0] CR3H_RSVD = 32'hffff_ff00;
  localparam logic [31:0] CR4_RSVD = 32'hff80_0000;
  localparam logic [31:0] EXTF_RSVD = 32'hffff_0200;
  localparam logic [31:0] INVALID_CODE = 32'hffff_ffff;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Exit classes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLS_OTHER = 3'h0;
  localparam logic [2:0] CLS_INSTR = 3'h1;
  localparam logic [2:0] CLS_MSR = 3'h2;
  localparam logic [2:0] CLS_PORTIO = 3'h3;
  localparam logic [2:0] CLS_BREAKPT = 3'h4;
  localparam logic [2:0] CLS_OVERFLOW = 3'h5;
  localparam logic [2:0] CLS_BOUND = 3'h6;
  localparam logic [2:0] CLS_EXTINT = 3'h7;
  // Winner of the event ordering
  localparam logic [2:0] WIN_NONE = 3'h0;
  localparam logic [2:0] WIN_EXC_ICPT = 3'h1;
  localparam logic [2:0] WIN_SIMPLE = 3'h2;
  localparam logic [2:0] WIN_BREAK = 3'h3;
  localparam logic [2:0] WIN_INSTR = 3'h4;
  localparam logic [2:0] WIN_OPERAND = 3'h5;
  localparam logic [2:0] WIN_PLAIN = 3'h6;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_SAVE_HOST, S_LOAD, S_CHECK, S_GUEST, S_X_INTR, S_X_WB,
    S_X_REASON, S_X_CLEAR, S_X_RELOAD, S_X_PTRS, S_X_FORCE, S_X_HCHECK,
    S_SHUTDOWN
  } state_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic df_pend;
    logic exc_icpt;
    logic opnd_exc;
    logic instr_icpt;
    logic bp_hit;
    logic simple_exc;
    logic ext_intr;
    logic trap;
    logic [2:0] cls;
    logic [15:0] reason;
  } cause_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic [1:0] priv;
    logic vm86;
    logic prot;
    logic [7:0] dbg_ctl;
    logic rip_bad;
    logic chk_bad;
    logic ptr_bad;
    logic reload_exc;
    logic paext;
    logic trc;
    logic resume;
  } host_t;

  typedef struct packed {
    logic [9:0] rsvd;
    logic gtrc;
    logic gresume;
    logic evinj_bad;
    logic cs_dflt;
    logic cs_long;
    logic entry_icpt;
    logic [15:0] space_id;
  } gmisc_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic vmask;
    logic shadow;
    logic [3:0] vtask_prio;
    logic virq;
  } virt_t;

  typedef struct packed {
    state_t st;
    cause_t cause;
    logic [31:0] info1, info2, cr0l, cr0h, cr3l, cr3h, cr4, extf, dsth, dcth;
    gmisc_t gm;
    logic [31:0] msr_top, io_top, seq_ip_in, rip_in;
    logic [63:0] seg;
    virt_t virt;
    logic [31:0] ts;
    host_t host;
    logic [31:0] rdata;
    logic err;
    logic glob_intr, shut, host_gp, host_dbg_trap, first_bp_supp;
    logic trace_first, guest_trace_trap, entry_bp_supp, intr_pend;
    logic chk_fail;
    logic [2:0] win;
    logic [31:0] x_reason, x_info1, x_info2, x_seq_ip, wb_rip;
    virt_t wb_virt;
    logic [15:0] cur_space;
    logic icpt_on;
    virt_t iv;
    logic [31:0] its;
  } regs_t;
endpackage : guest_exit_pkg

// ---- testbench/guest_exit_props.sv ----
/*
  Checker for the guest entry check and exit block: watches the APB port
  and the run, interrupt and shutdown outputs.
  Assumes it is bound to the block's top module, clocked by pclk.
*/
`timescale 1ns/10ps
module guest_exit_props import guest_exit_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic glob_intr,
  input wire logic guest_running,
  input wire logic shutdown
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic entry_wr;
  assign acc = psel && penable;
  assign entry_wr = acc && pwrite && paddr == OFF_CTRL && pwdata[CTRL_ENTRY];
  sequence s_entry_wr;
    entry_wr && !guest_running;
  endsequence
  sequence s_exit_start;
    $fell(guest_running);
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_ready;
    pready;
  endproperty
  property p_err_unmapped;
    acc && paddr > OFF_SPACE |-> pslverr;
  endproperty
  property p_err_access;
    pslverr |-> acc;
  endproperty
  property p_entry_wait;
    s_entry_wr |=> (!guest_running)[*3];
  endproperty
  property p_entry_rise;
    $rose(guest_running) |-> $past(entry_wr, 4) && glob_intr;
  endproperty
  property p_gif_clear;
    s_exit_start |=> !glob_intr;
  endproperty
  property p_exit_order;
    s_exit_start |-> (!shutdown)[*5];
  endproperty
  property p_shut_hold;
    shutdown |=> shutdown;
  endproperty
  property p_shut_idle;
    shutdown |-> !guest_running && !glob_intr;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
  a_err_access: assert property (p_err_access) else $error("error outside access");
  a_entry_wait: assert property (p_entry_wait) else $error("guest ran early");
  a_entry_rise: assert property (p_entry_rise) else $error("bad guest start");
  a_gif_clear: assert property (p_gif_clear) else $error("flag kept on exit");
  a_exit_order: assert property (p_exit_order) else $error("early shutdown");
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown dropped");
  a_shut_idle: assert property (p_shut_idle) else $error("active in shutdown");
endmodule : guest_exit_props

// ---- testbench/testbench.sv ----
/*
  Self-checking testbench for the guest entry check and exit block.
  Assumes the package, the design and the checker compile before it.
*/
`timescale 1ns/10ps
module testbench import guest_exit_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic glob_intr, guest_running, shutdown, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st, rv, cv;
  int bad_count, comparisons;
  logic [39:0] base_row [14] = '{{OFF_CR0L, 32'h1}, {OFF_CR0H, 32'h0}, {OFF_CR3L, 32'h0},
    {OFF_CR3H, 32'h0}, {OFF_CR4, 32'h0}, {OFF_EXTF, 32'h1000}, {OFF_DSTH, 32'h0},
    {OFF_DCTH, 32'h0}, {OFF_GMISC, 32'h0001_0005}, {OFF_MSRTOP, 32'h0},
    {OFF_IOTOP, 32'h0}, {OFF_HOST, 32'h0}, {OFF_SEGH, 32'h0}, {OFF_TSOFF, 32'h55}};
  logic [39:0] bad_row [16] = '{{OFF_EXTF, 32'h0}, {OFF_CR0L, 32'h2000_0001},
    {OFF_CR0H, 32'h1}, {OFF_DSTH, 32'h8000_0000}, {OFF_DCTH, 32'h1}, {OFF_CR3L, 32'h1},
    {OFF_CR3H, 32'h100}, {OFF_CR4, 32'h0080_0000}, {OFF_EXTF, 32'h1200},
    {OFF_GMISC, 32'h0001_0000}, {OFF_GMISC, 32'h5}, {OFF_CR0L, 32'h8000_0001},
    {OFF_CR0L, 32'h8000_0000}, {OFF_MSRTOP, 32'h0100_0000}, {OFF_IOTOP, 32'h0100_0000},
    {OFF_GMISC, 32'h0009_0005}};
  logic [31:0] ord_cause [6] = '{32'h0620_0000, 32'h00e0_0000, 32'h01c0_0000,
    32'h0180_0000, 32'h0100_0000, 32'h0};
  logic [31:0] host_val [5] = '{32'h8, 32'h14, 32'h10, 32'h20, 32'h40};
  logic [2:0] host_exp [5] = '{3'h2, 3'h2, 3'h0, 3'h2, 3'h4};

  guest_entry_check_and_exit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .glob_intr(glob_intr),
    .guest_running(guest_running), .shutdown(shutdown));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task close_out;
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // One transfer, then an idle cycle so the next one starts on a new edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rv);
    check(rv, e);
  endtask : rd_chk

  task do_reset;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  task set_base;
    for (int i = 0; i < 14; i++) wr(base_row[i][39:32], base_row[i][31:0]);
  endtask : set_base

  // Poll until the sequencer rests: guest running, shut down or idle
  task wait_done;
    do apb(1'b0, OFF_STAT, 32'h0, st); while (!(st[1] | st[2] | !st[10]));
  endtask : wait_done

  task try_entry(input logic ok);
    wr(OFF_CTRL, 32'h1);
    wait_done;
    check(32'({st[1], st[9]}), 32'({ok, !ok}));
    if (!ok) begin
      rd_chk(OFF_XREASON, INVALID_CODE);
      rd_chk(OFF_XNRIP, 32'h0);
    end
  endtask : try_entry

  task do_exit(input logic [31:0] cause);
    wr(OFF_CAUSE, cause);
    wr(OFF_CTRL, 32'h2);
    wait_done;
  endtask : do_exit

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    comparisons = 0;
    do_reset;
    rd_chk(OFF_STAT, 32'h0);
    apb(1'b0, 8'h78, 32'h0, rv);
    check(32'({err_seen, rv != 32'h0}), 32'h2);
    wr(OFF_XREASON, 32'h5);
    rd_chk(OFF_XREASON, 32'h0);
    for (int i = 0; i < 16; i++) begin
      set_base;
      wr(bad_row[i][39:32], bad_row[i][31:0]);
      if (i == 11 || i == 12) wr(OFF_EXTF, 32'h1100);
      if (i == 12) wr(OFF_CR4, 32'h20);
      try_entry(1'b0);
    end
    set_base;
    wr(OFF_CR0L, 32'h8000_0000);
    wr(OFF_MSRTOP, 32'h00ff_ffff);
    try_entry(1'b1);
    do_exit(32'h0);
    wr(OFF_CR0L, 32'h8000_0001);
    wr(OFF_EXTF, 32'h1100);
    wr(OFF_CR4, 32'h20);
    try_entry(1'b1);
    do_exit(32'h0);
    wr(OFF_GMISC, 32'h0007_0005);
    try_entry(1'b0);
    for (int c = 0; c < 8; c++) begin
      cv = 32'(c);
      set_base;
      wr(OFF_GMISC, 32'h0031_0005);
      wr(OFF_HOST, 32'h0007_7f83);
      wr(OFF_SEGH, 32'h0000_8000);
      wr(OFF_VIRT, 32'h7f);
      wr(OFF_NRIPIN, 32'h1234);
      wr(OFF_RIPIN, 32'h1230);
      wr(OFF_INFO1, cv);
      wr(OFF_INFO2, ~cv);
      try_entry(1'b1);
      check(32'({st[7], st[5], st[11], st[4]}), 32'hc);
      rd_chk(OFF_SEGH, 32'hffff_8000);
      rd_chk(OFF_SPACE, 32'hf000_0005);
      wr(OFF_CTRL, 32'h8);
      apb(1'b0, OFF_STAT, 32'h0, st);
      check(32'({st[5], st[11]}), 32'h1);
      do_exit({12'h0, cv[0], cv[2:0], 16'h60 + cv[15:0]});
      check(32'({st[8], st[4], st[0]}), 32'({c == 7, 2'b10}));
      rd_chk(OFF_XREASON, 32'h60 + cv);
      rd_chk(OFF_XINFO1, cv);
      rd_chk(OFF_XINFO2, ~cv);
      rd_chk(OFF_XNRIP, (c >= 1 && c <= 6) ? 32'h1234 : 32'h0);
      rd_chk(OFF_WBRIP, cv[0] ? 32'h1234 : 32'h1230);
      rd_chk(OFF_WBVIRT, 32'h7f);
      rd_chk(OFF_SPACE, 32'h0);
      rd_chk(OFF_HOST, 32'h0000_8002);
      rd_chk(OFF_SEGH, 32'hffff_8000);
    end
    wr(OFF_CTRL, 32'h4);
    apb(1'b0, OFF_STAT, 32'h0, st);
    check(32'(st[8]), 32'h0);
    set_base;
    for (int k = 0; k < 6; k++) begin
      if (st[1] !== 1'b1) try_entry(1'b1);
      do_exit(ord_cause[k]);
      check(32'({st[14:12], st[1]}), 32'({3'(k + 1), k == 1 || k == 2 || k == 4}));
    end
    for (int h = 0; h < 5; h++) begin
      set_base;
      wr(OFF_HOST, host_val[h]);
      try_entry(1'b1);
      do_exit(32'h0);
      check(32'({st[3], shutdown, glob_intr}), 32'(host_exp[h]));
      if (shutdown === 1'b1) do_reset;
    end
    close_out;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    close_out;
  end
endmodule : testbench

bind guest_entry_check_and_exit guest_exit_props chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .glob_intr(glob_intr),
  .guest_running(guest_running), .shutdown(shutdown));
